// >>> txb_pkg.sv
// Shared constants for the transmit buffer and interrupt controller and its host end.
// Assumes a single core clock at 10 MHz on both ends and a four-wire serial link.
//
// Functional notes
// - Mode field value 01 selects transmit.
// - Bit period from range, limit, extension fields.
// - Keying select picks amplitude or frequency keying.
// - Pattern mode sends buffer bits as NRZ.
// - Start-up with synthesizer until lock reported.
// - Buffer writes accepted in start-up and active.
// - Send automatically when buffered, MSB first.
// - Host refills buffer at the sending rate.
// - Pending counter counts loads up, sends down.
// - Interrupt when counting down hits threshold.
// - Control writes flush buffer and counter.
// - Transparent mode keys from serial input level.
// - Manchester one rises, zero falls.
// - NRZ one high or on, zero low or off.
// - Interrupt output high on any enabled condition.
// - Status changes interrupt; status read clears.
// - Threshold interrupt cleared by writes or delete.
// - Receive count threshold or error interrupts.
// - Bit-check success interrupts only without pattern.
// - Receive interrupts cleared by read, write, delete.
// - No receive threshold or error interrupts while host reads buffer; bit-check success still interrupts.
// - Host reads status first, then services buffer.
`default_nettype none
package txb_pkg;
    // Serial frame: command byte {cmd, index, 2'b00} then one data byte.
    localparam int       FRAME_BITS    = 16;
    localparam logic [2:0] CMD_WR_CTRL = 3'h1;
    localparam logic [2:0] CMD_WR_BUF  = 3'h2;
    localparam logic [2:0] CMD_RD_STAT = 3'h3;
    localparam logic [2:0] CMD_RD_CNT  = 3'h4;
    localparam logic [2:0] CMD_DEL_IRQ = 3'h5;
    localparam logic [2:0] CMD_RD_BUF  = 3'h6;
    // Control register indices.
    localparam logic [2:0] CR1_IDX = 3'h1;
    localparam logic [2:0] CR4_IDX = 3'h4;
    localparam logic [2:0] CR5_IDX = 3'h5;
    localparam logic [2:0] CR6_IDX = 3'h6;
    // Control register 1 fields.
    localparam int MODE_LO_POS  = 0;
    localparam int THR_LO_POS   = 2;
    localparam int PATTERN_POS  = 4;
    localparam int TRANSP_POS   = 5;
    localparam logic [1:0] MODE_TX = 2'h1;
    localparam logic [1:0] THR_EMPTY_SEL = 2'h3;
    // Control register 4, 5, 6 fields.
    localparam int ASK_POS      = 0;
    localparam int EXTENDED_LIMIT_SELECT_POS     = 1;
    localparam int LIM_W        = 6;
    localparam int RANGE_W      = 2;
    localparam logic [7:0] CR_RESET = 8'h00;
    // Buffer and threshold figures.
    localparam int BUF_DEPTH = 16;
    localparam logic [4:0] THR_4  = 5'h04;
    localparam logic [4:0] THR_8  = 5'h08;
    localparam logic [4:0] THR_12 = 5'h0c;
    localparam logic [4:0] THR_0  = 5'h00;
    // Host side Avalon word offsets (byte addresses).
    localparam logic [3:0] AV_CMD  = 4'h0;
    localparam logic [3:0] AV_CTRL = 4'h4;
    localparam logic [3:0] AV_STAT = 4'h8;
    // Host serial clock half period in core clocks.
    localparam int SCK_HALF_CYC = 8;
endpackage
`default_nettype wire

// >>> txb_link_if.sv
// Four-wire serial link plus interrupt line between host and transceiver logic.
// Assumes both ends run on the same core clock; the data-out pin resolves to low when undriven.
`default_nettype none
interface txb_link_if;
    logic sck;
    logic sel_b;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    logic irq;
    wire  sdo;

    // Pin level of the device data output, pulled low when released.
    assign sdo = sdo_oe ? sdo_out : 1'b0;

    modport device (input sck, input sel_b, input sdi, output sdo_out, output sdo_oe, output irq);
    modport host   (output sck, output sel_b, output sdi, input sdo, input irq);
endinterface
`default_nettype wire

// >>> txb_device.sv
// Transceiver transmit control: mode sequencing, byte buffer, serialiser and interrupt line.
// Assumes link pins arrive asynchronously and are synchronised here; receive events come from same-clock logic.
`default_nettype none
module txb_device
    import txb_pkg::*;
#(
    parameter int ST_W  = 4,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic            core_clk,
    input  wire logic            rst_b,
    txb_link_if.device           link,
    input  wire logic            pll_lock,
    input  wire logic [ST_W-1:0] state_status_bits,
    input  wire logic            power_up_flag,
    input  wire logic            aux_power_flag,
    input  wire logic            rx_byte_valid,
    input  wire logic [7:0]      rx_byte,
    input  wire logic            rx_error,
    input  wire logic            bitcheck_ok,
    output logic                 synth_en,
    output logic                 tx_active,
    output logic                 carrier_on,
    output logic                 fsk_high
);
    localparam int AW   = $clog2(DEPTH);
    localparam int SY_W = ST_W + 6;
    // Synchroniser reset pattern: frame select rests high so no false frame follows reset.
    localparam logic [SY_W-1:0] SY_IDLE = SY_W'(1) << (ST_W + 4);

    typedef enum logic [1:0] {
        TXB_IDLE  = 2'b00,
        TXB_START = 2'b01,
        TXB_ACT   = 2'b10
    } txb_mode_e;

    // Threshold selector to byte count; the empty choice only applies while sending.
    function automatic logic [4:0] txb_thr(input logic [1:0] sel);
        case (sel)
            2'h0:    txb_thr = THR_4;
            2'h1:    txb_thr = THR_8;
            2'h2:    txb_thr = THR_12;
            default: txb_thr = THR_0;
        endcase
    endfunction

    logic [SY_W-1:0] sy1_q;
    logic [SY_W-1:0] sy2_q;
    logic [SY_W-1:0] sy3_q;
    logic [4:0]      bit_cnt_q;
    logic [6:0]      in_sh_q;
    logic [2:0]      cmd_q;
    logic [2:0]      idx_q;
    logic [7:0]      out_sh_q;
    logic            sdo_oe_q;
    logic            rd_frame_q;
    logic [7:0]      cr1_q;
    logic [7:0]      cr4_q;
    logic [7:0]      cr5_q;
    logic [7:0]      cr6_q;
    txb_mode_e       mode_q;
    txb_mode_e       mode_d;
    logic [7:0]      mem [DEPTH];
    logic [AW-1:0]   wr_ptr_q;
    logic [AW-1:0]   rd_ptr_q;
    logic [AW:0]     cnt_q;
    logic            busy_q;
    logic [7:0]      sh_q;
    logic [2:0]      bit_i_q;
    logic            half_q;
    logic [11:0]     tmr_q;
    logic            stat_irq_q;
    logic            tx_irq_q;
    logic            rx_irq_q;
    logic            irq_q;
    logic            synth_en_q;
    logic            tx_active_q;
    logic            carrier_q;
    logic            fsk_q;

    // Three-flop synchronisers; only the second and third stages feed logic.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sy1_q <= SY_IDLE;
            sy2_q <= SY_IDLE;
            sy3_q <= SY_IDLE;
        end else begin
            sy1_q <= {link.sck, link.sel_b, link.sdi, pll_lock, power_up_flag, aux_power_flag, state_status_bits};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    wire            sck_s     = sy2_q[ST_W+5];
    wire            sel_b_s   = sy2_q[ST_W+4];
    wire            sdi_s     = sy2_q[ST_W+3];
    wire            lock_s    = sy2_q[ST_W+2];
    wire            pwr_rise  = sy2_q[ST_W+1] & ~sy3_q[ST_W+1];
    wire            aux_rise  = sy2_q[ST_W] & ~sy3_q[ST_W];
    wire            st_change = sy2_q[ST_W-1:0] != sy3_q[ST_W-1:0];
    wire            sck_rise  = sck_s & ~sy3_q[ST_W+5] & ~sel_b_s;
    wire            sck_fall  = ~sck_s & sy3_q[ST_W+5] & ~sel_b_s;
    wire [7:0]      rx_word   = {in_sh_q, sdi_s};
    wire            byte1     = sck_rise && bit_cnt_q == 5'd7;
    wire            frame_end = sck_rise && bit_cnt_q == 5'(FRAME_BITS - 1);
    wire [2:0]      cmd_now   = rx_word[7:5];

    // Control fields.
    wire [1:0]      mode_sel  = cr1_q[MODE_LO_POS+1:MODE_LO_POS];
    wire [1:0]      thr_sel   = cr1_q[THR_LO_POS+1:THR_LO_POS];
    wire            pattern   = cr1_q[PATTERN_POS];
    wire            transp    = cr1_q[TRANSP_POS];
    wire            ask       = cr4_q[ASK_POS];
    wire            extended_limit_select      = cr4_q[EXTENDED_LIMIT_SELECT_POS];
    wire [LIM_W-1:0]   lim    = cr5_q[LIM_W-1:0];
    wire [RANGE_W-1:0] range  = cr6_q[RANGE_W-1:0];

    // Decoded link operations.
    wire idx_ok   = idx_q == CR1_IDX || idx_q == CR4_IDX || idx_q == CR5_IDX || idx_q == CR6_IDX;
    wire ctrl_wr  = frame_end && cmd_q == CMD_WR_CTRL && idx_ok;
    wire buf_wr   = frame_end && cmd_q == CMD_WR_BUF && !transp;
    wire stat_rd  = byte1 && cmd_now == CMD_RD_STAT;
    wire del_irq  = byte1 && cmd_now == CMD_DEL_IRQ;
    wire buf_rd   = byte1 && cmd_now == CMD_RD_BUF && cnt_q != '0;
    wire full     = cnt_q == (AW+1)'(DEPTH);
    wire push     = (buf_wr || rx_byte_valid) && !full && !ctrl_wr;
    wire tx_load  = mode_q == TXB_ACT && !busy_q && cnt_q != '0 && !transp && !ctrl_wr && !buf_rd;
    wire pop      = (buf_rd || tx_load) && !ctrl_wr;
    wire [AW:0] cnt_next = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    wire [7:0] stat_byte = 8'({sy2_q[ST_W], sy2_q[ST_W+1], sy2_q[ST_W-1:0]});
    wire [7:0] rd_byte   = cmd_now == CMD_RD_STAT ? stat_byte :
                           cmd_now == CMD_RD_CNT  ? 8'(cnt_q) :
                           cmd_now == CMD_RD_BUF  ? mem[rd_ptr_q] : 8'h00;

    // half-bit time from range, limit and extension
    wire [11:0] half_cyc = ((12'(lim) + 12'h001) << range) << extended_limit_select;
    wire        tick     = tmr_q == 12'h000;

    // Serial frame reception, read data shifting and control registers.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bit_cnt_q  <= '0;
            in_sh_q    <= '0;
            cmd_q      <= '0;
            idx_q      <= '0;
            out_sh_q   <= '0;
            sdo_oe_q   <= 1'b0;
            rd_frame_q <= 1'b0;
            cr1_q      <= CR_RESET;
            cr4_q      <= CR_RESET;
            cr5_q      <= CR_RESET;
            cr6_q      <= CR_RESET;
        end else begin
            sdo_oe_q <= !sel_b_s;
            if (sel_b_s) begin
                bit_cnt_q  <= '0;
                rd_frame_q <= 1'b0;
            end else if (sck_rise) begin
                bit_cnt_q <= bit_cnt_q + 5'd1;
                in_sh_q   <= rx_word[6:0];
            end
            if (byte1) begin
                cmd_q      <= cmd_now;
                idx_q      <= rx_word[4:2];
                out_sh_q   <= rd_byte;
                rd_frame_q <= cmd_now == CMD_RD_BUF;
            end else if (sck_fall && bit_cnt_q > 5'd8) begin
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
            if (ctrl_wr && idx_q == CR1_IDX) cr1_q <= rx_word;
            if (ctrl_wr && idx_q == CR4_IDX) cr4_q <= rx_word;
            if (ctrl_wr && idx_q == CR5_IDX) cr5_q <= rx_word;
            if (ctrl_wr && idx_q == CR6_IDX) cr6_q <= rx_word;
        end
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            TXB_IDLE:  if (mode_sel == MODE_TX) mode_d = TXB_START;
            TXB_START: if (lock_s) mode_d = TXB_ACT;
            TXB_ACT:   mode_d = TXB_ACT;
            default:   mode_d = TXB_IDLE;
        endcase
        if (mode_sel != MODE_TX) mode_d = TXB_IDLE;
    end

    // Buffer storage; contents need no reset.
    always_ff @(posedge core_clk) begin
        if (push) mem[wr_ptr_q] <= buf_wr ? rx_word : rx_byte;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b || ctrl_wr) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            if (push) wr_ptr_q <= wr_ptr_q + AW'(1);
            if (pop)  rd_ptr_q <= rd_ptr_q + AW'(1);
            cnt_q <= cnt_next;
        end
    end

    // byte serialiser, MSB first, two half-bit slots per bit
    always_ff @(posedge core_clk) begin
        if (!rst_b || ctrl_wr) begin
            mode_q  <= TXB_IDLE;
            busy_q  <= 1'b0;
            sh_q    <= '0;
            bit_i_q <= '0;
            half_q  <= 1'b0;
            tmr_q   <= '0;
        end else begin
            mode_q <= (ctrl_wr) ? TXB_IDLE : mode_d;
            if (tx_load) begin
                busy_q  <= 1'b1;
                sh_q    <= mem[rd_ptr_q];
                bit_i_q <= '0;
                half_q  <= 1'b0;
                tmr_q   <= half_cyc;
            end else if (busy_q && tick) begin
                tmr_q  <= half_cyc;
                half_q <= !half_q;
                if (half_q) begin
                    sh_q    <= {sh_q[6:0], 1'b0};
                    bit_i_q <= bit_i_q + 3'd1;
                    busy_q  <= bit_i_q != 3'd7;
                end
            end else if (busy_q) begin
                tmr_q <= tmr_q - 12'h001;
            end
        end
    end

    wire level = transp ? sdi_s : (pattern ? sh_q[7] : (sh_q[7] ^ ~half_q));
    wire keyed = mode_q == TXB_ACT && (transp || busy_q);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            synth_en_q  <= 1'b0;
            tx_active_q <= 1'b0;
            carrier_q   <= 1'b0;
            fsk_q       <= 1'b0;
        end else begin
            synth_en_q  <= mode_q != TXB_IDLE;
            tx_active_q <= mode_q == TXB_ACT;
            carrier_q   <= keyed && (ask ? level : 1'b1);
            fsk_q       <= keyed && !ask && level;
        end
    end

    // Interrupt source terms; set wins over clear.
    wire rx_mode  = !transp && mode_sel != MODE_TX;
    wire rx_thr   = rx_byte_valid && push && rx_mode && thr_sel != THR_EMPTY_SEL && cnt_next == txb_thr(thr_sel);
    wire tx_set   = tx_load && !push && !transp && cnt_next == txb_thr(thr_sel);
    wire rx_set   = (!rd_frame_q && (rx_thr || (rx_error && rx_mode))) || (bitcheck_ok && !pattern);
    wire stat_set = st_change || pwr_rise || aux_rise;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stat_irq_q <= 1'b0;
            tx_irq_q   <= 1'b0;
            rx_irq_q   <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            stat_irq_q <= stat_set || (stat_irq_q && !(stat_rd || del_irq));
            tx_irq_q   <= tx_set || (tx_irq_q && !(buf_wr || ctrl_wr || del_irq));
            rx_irq_q   <= rx_set || (rx_irq_q && !(buf_rd || ctrl_wr || del_irq));
            irq_q      <= stat_irq_q || tx_irq_q || rx_irq_q;
        end
    end

    assign link.sdo_out = out_sh_q[7];
    assign link.sdo_oe  = sdo_oe_q;
    assign link.irq     = irq_q;
    assign synth_en     = synth_en_q;
    assign tx_active    = tx_active_q;
    assign carrier_on   = carrier_q;
    assign fsk_high     = fsk_q;
endmodule
`default_nettype wire

// >>> txb_host.sv
// Host end: Avalon-MM slave with waitrequest that runs serial frames to the transceiver.
// Assumes the same core clock as the device; the serial clock is made here by a divider.
`default_nettype none
module txb_host
    import txb_pkg::*;
#(
    parameter int HALF = SCK_HALF_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    txb_link_if.host         link,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [1:0]  ctrl_q;
    logic        busy_q;
    logic [7:0]  div_q;
    logic        sck_q;
    logic        sel_b_q;
    logic        sdi_q;
    logic [4:0]  bit_q;
    logic [15:0] sh_q;
    logic [7:0]  rx_q;
    logic [1:0]  sdo_sy_q;
    logic [1:0]  irq_sy_q;

    // Request decode; a command write waits while a frame runs.
    wire req      = avs_read || avs_write;
    wire cmd_wr   = avs_write && avs_address == AV_CMD;
    wire stall    = cmd_wr && busy_q;
    wire accept   = req && !wait_q;
    wire start    = accept && cmd_wr;
    wire div_tick = div_q == 8'h00;
    wire [31:0] rd_mux = avs_address == AV_CMD  ? {23'h000000, busy_q, rx_q} :
                         avs_address == AV_CTRL ? {30'h00000000, ctrl_q} :
                         avs_address == AV_STAT ? {30'h00000000, irq_sy_q[1], busy_q} : 32'h00000000;

    // Bus answer: waitrequest drops one cycle after the request is seen.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
            ctrl_q  <= '0;
        end else begin
            wait_q <= !(req && wait_q && !stall);
            if (req && wait_q) rdata_q <= rd_mux;
            if (accept && avs_write && avs_address == AV_CTRL) ctrl_q <= avs_writedata[1:0];
        end
    end

    // Synchronisers for device data out and interrupt.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sdo_sy_q <= '0;
            irq_sy_q <= '0;
        end else begin
            sdo_sy_q <= {sdo_sy_q[0], link.sdo};
            irq_sy_q <= {irq_sy_q[0], link.irq};
        end
    end

    // frame engine sends command byte then data byte, MSB first.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            busy_q  <= 1'b0;
            div_q   <= '0;
            sck_q   <= 1'b0;
            sel_b_q <= 1'b1;
            sdi_q   <= 1'b0;
            bit_q   <= '0;
            sh_q    <= '0;
            rx_q    <= '0;
        end else if (start) begin
            busy_q  <= 1'b1;
            sel_b_q <= 1'b0;
            sck_q   <= 1'b0;
            bit_q   <= '0;
            sh_q    <= {avs_writedata[7:0], avs_writedata[15:8]};
            sdi_q   <= avs_writedata[7];
            div_q   <= 8'(HALF - 1);
        end else if (busy_q && !div_tick) begin
            div_q <= div_q - 8'h01;
        end else if (busy_q) begin
            div_q <= 8'(HALF - 1);
            if (bit_q == 5'(FRAME_BITS + 1)) begin
                busy_q <= 1'b0;
            end else if (bit_q == 5'(FRAME_BITS)) begin
                sel_b_q <= 1'b1;
                bit_q   <= bit_q + 5'd1;
            end else if (!sck_q) begin
                sck_q <= 1'b1;
                rx_q  <= {rx_q[6:0], sdo_sy_q[1]};
            end else begin
                sck_q <= 1'b0;
                bit_q <= bit_q + 5'd1;
                sdi_q <= sh_q[14];
                sh_q  <= {sh_q[14:0], 1'b0};
            end
        end else begin
            sdi_q <= ctrl_q[1] & ctrl_q[0];
        end
    end

    assign link.sck        = sck_q;
    assign link.sel_b      = sel_b_q;
    assign link.sdi        = sdi_q;
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule
`default_nettype wire

// >>> txb_link_asserts.sv
// Concurrent checks on the serial link between host and device; the interrupt line is brought in but not checked.
// Assumes instantiation beside the link interface, with the host divider value handed on.
`default_nettype none
module txb_link_asserts #(
    parameter int HALF = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sck,
    input wire logic sel_b,
    input wire logic sdi,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic irq,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hi_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Counts the cycles of each high phase of the serial clock.
    always_ff @(posedge core_clk) hi_q <= (!rst_b || !sck) ? 8'h00 : hi_q + 8'h01;

    chk_sck_idle_low: assert property (sel_b |-> !sck) else $error("serial clock high while idle");
    chk_sck_in_frame: assert property ($rose(sck) |-> !sel_b) else $error("clock edge outside frame");
    chk_sck_high_width: assert property ($fell(sck) |-> hi_q == 8'(HALF)) else $error("clock high width");
    chk_first_edge_gap: assert property ($fell(sel_b) |-> !sck [*6]) else $error("clock too soon");
    chk_sdi_hold_high: assert property ($rose(sck) |=> $stable(sdi) [*6]) else $error("data moved");
    chk_sel_rise_quiet: assert property ($rose(sel_b) |-> !$past(sck, 4)) else $error("frame cut");
    chk_oe_released: assert property (sel_b [*4] |-> !sdo_oe) else $error("data out driven idle");
    chk_oe_driven: assert property (!sel_b [*5] |-> sdo_oe) else $error("data out not driven");
    chk_sdo_released: assert property (!sdo_oe |-> !sdo) else $error("released data out not low");
endmodule
`default_nettype wire

// >>> tx_buffer_and_irq_control_test.sv
// Testbench joining host and device ends over the link, driven through the host's Avalon port.
// Assumes a 10 MHz core clock and the package's command and register encodings.
`default_nettype none
module tx_buffer_and_irq_control_test;
    import txb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rst_b, pll_lock, power_up_flag, bitcheck_ok, aux_power_flag, rx_byte_valid, rx_error;
    logic [3:0]  state_status_bits, avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic        synth_en, tx_active, carrier_on, fsk_high;
    logic [7:0]  rep, seen, fst, rx_byte;
    int          miscompares = 0;
    int          checks = 0;

    txb_link_if link ();
    txb_device i_txb_device (.core_clk, .rst_b, .link(link.device), .pll_lock, .state_status_bits,
        .power_up_flag, .aux_power_flag, .rx_byte_valid, .rx_byte, .rx_error,
        .bitcheck_ok, .synth_en, .tx_active, .carrier_on, .fsk_high);
    txb_host i_txb_host (.core_clk, .rst_b, .link(link.host), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    txb_link_asserts #(.HALF(SCK_HALF_CYC)) i_txb_link_asserts (.core_clk, .rst_b, .sck(link.sck),
        .sel_b(link.sel_b), .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe), .irq(link.irq),
        .sdo(link.sdo));

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Compares one result and reports a mismatch at once.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low.
    task automatic av(input logic rd, input logic [3:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        avs_address <= addr;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= wd;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Runs one serial frame and fetches the byte the device returned.
    task automatic frame(input logic [2:0] cmd, input logic [2:0] idx, input logic [7:0] d);
        av(1'b0, AV_CMD, {16'h0000, d, cmd, idx, 2'b00});
        do av(1'b1, AV_STAT, 32'h0); while (rdat[0] !== 1'b0);
        av(1'b1, AV_CMD, 32'h0);
        rep = rdat[7:0];
    endtask

    // Makes the core clock.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Captures both half-bit levels of eight bits, bit period 2*(3+1+1), once the carrier comes up.
    initial begin
        forever begin
            @(posedge carrier_on);
            for (int b = 7; b >= 0; b--) begin
                repeat (3) @(negedge core_clk);
                fst[b] = fsk_high;
                repeat (5) @(negedge core_clk);
                seen[b] = fsk_high;
                repeat (2) @(negedge core_clk);
            end
        end
    end

    // Cuts a hang short.
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        test_done();
    end

    // Main sequence.
    initial begin
        {rst_b, pll_lock, power_up_flag, aux_power_flag, bitcheck_ok, rx_byte_valid, rx_error, avs_read, avs_write} = 9'h000;
        state_status_bits = 4'h0;
        rx_byte = 8'h00;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        check("irq after reset", 0, link.irq);
        frame(CMD_WR_CTRL, CR5_IDX, 8'h03);
        frame(CMD_WR_CTRL, CR6_IDX, 8'h00);
        frame(CMD_WR_CTRL, CR4_IDX, 8'h00);
        for (int t = 0; t < 4; t++) begin
            @(posedge core_clk);
            pll_lock <= 1'b0;
            frame(CMD_WR_CTRL, CR1_IDX, {3'b000, t[0], t[1:0], MODE_TX});
            check("irq after control write", 0, link.irq);
            frame(CMD_RD_CNT, 3'h0, 8'h00);
            check("count after flush", 0, rep);
            // Two bytes above the threshold, so it is reached only as the second byte leaves.
            for (int i = 0; i < ((t == 3) ? 2 : 4 * t + 6); i++) frame(CMD_WR_BUF, 3'h0, 8'ha5);
            frame(CMD_RD_CNT, 3'h0, 8'h00);
            check("pending count", (t == 3) ? 2 : 4 * t + 6, rep);
            check("start-up", 2'b10, {synth_en, tx_active});
            pll_lock <= 1'b1;
            repeat (40) @(negedge core_clk);
            check("irq before threshold", 0, link.irq);
            check("active", 1, tx_active);
            repeat (100) @(negedge core_clk);
            check("irq at threshold", 1, link.irq);
            check("second halves", 8'ha5, seen);
            check("first halves", t[0] ? 8'ha5 : 8'h5a, fst);
        end
        frame(CMD_WR_CTRL, CR1_IDX, 8'h21);
        for (int v = 0; v < 2; v++) begin
            av(1'b0, AV_CTRL, {30'h0, 1'b1, v[0]});
            repeat (10) @(negedge core_clk);
            check("transparent level", v, fsk_high);
        end
        @(posedge core_clk);
        state_status_bits <= 4'h5;
        repeat (10) @(negedge core_clk);
        check("irq on status change", 1, link.irq);
        frame(CMD_RD_STAT, 3'h0, 8'h00);
        check("status byte", 8'h05, rep);
        check("irq after status read", 0, link.irq);
        @(posedge core_clk);
        power_up_flag <= 1'b1;
        aux_power_flag <= 1'b1;
        bitcheck_ok <= 1'b1;
        @(posedge core_clk);
        bitcheck_ok <= 1'b0;
        frame(CMD_RD_STAT, 3'h0, 8'h00);
        check("status byte with power flags", 8'h35, rep);
        check("irq held by bit-check", 1, link.irq);
        frame(CMD_DEL_IRQ, 3'h0, 8'h00);
        check("irq after delete", 0, link.irq);
        // Receive side: four bytes arrive outside transmit with the threshold at four.
        frame(CMD_WR_CTRL, CR1_IDX, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            rx_byte_valid <= 1'b1;
            rx_byte <= 8'h3c + 8'(i);
            @(posedge core_clk);
            rx_byte_valid <= 1'b0;
        end
        repeat (4) @(negedge core_clk);
        check("irq at receive threshold", 1, link.irq);
        frame(CMD_RD_BUF, 3'h0, 8'h00);
        check("first received byte", 8'h3c, rep);
        check("irq after buffer read", 0, link.irq);
        @(posedge core_clk);
        rx_error <= 1'b1;
        @(posedge core_clk);
        rx_error <= 1'b0;
        repeat (4) @(negedge core_clk);
        check("irq on receive error", 1, link.irq);
        frame(CMD_WR_CTRL, CR6_IDX, 8'h00);
        check("irq after receive flush", 0, link.irq);
        test_done();
    end
endmodule
`default_nettype wire
